// ---- core/pwi_pkg.sv ----
/*
 * Constants shared by the pin wake interrupt unit: register addresses,
 * field positions, reset values and sizes.
 * Assumes a byte-wide register port with a 16-bit address.
 */
package pwi_pkg;
    // ****************************************************************
    // Bus sizes
    // ****************************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int MAX_PINS = 8;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_STATUS_CONTROL = 16'h003c;
    localparam logic [ADDR_W-1:0] ADDR_PIN_ENABLE = 16'h307c;
    localparam logic [ADDR_W-1:0] ADDR_POLARITY = 16'h307d;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 16'h3080;
    localparam logic [ADDR_W-1:0] ADDR_EVT_CLEAR = 16'h3081;
    localparam logic [ADDR_W-1:0] ADDR_EVT_ENABLE = 16'h3082;

    // ****************************************************************
    // Status/control fields
    // ****************************************************************
    localparam int SC_MODE_BIT = 0;
    localparam int SC_IE_BIT = 1;
    localparam int SC_ACK_BIT = 2;
    localparam int SC_FLAG_BIT = 3;
    localparam logic [3:0] SC_RESERVED_VALUE = 4'h0;

    // ****************************************************************
    // Event status fields
    // ****************************************************************
    localparam int EVT_W = 3;
    localparam int EVT_FLAG_RISE = 0;
    localparam int EVT_EDGE_SEEN = 1;
    localparam int EVT_ACK_REFUSED = 2;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam logic [EVT_W-1:0] RESET_EVT = 3'h0;
    localparam int SYNC_STAGES = 2;
endpackage

// ---- core/pwi_pin_sync.sv ----
/*
 * Two-stage synchroniser for the external wake pins.
 * Assumes the pins are asynchronous to i_clock; the first stage feeds
 * only the second.
 */
`timescale 1ns/100ps
module pwi_pin_sync
#(
    parameter int WIDTH = 8
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    import pwi_pkg::*;

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb
    begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ---- core/pwi_unit.sv ----
/*
 * Pin wake interrupt unit: up to eight external pins raise one shared
 * event flag by edge or by edge-and-level detection, with an interrupt
 * request, a wake request and a small event status block.
 * Assumes a single 20 MHz clock, a synchronous active-low reset and a
 * byte-wide register port whose master never waits.
 */
// How it works
// - Status/control bits 7..4 always read zero
// - Bit 3 shows event flag, writes ignored
// - Writing 1 to bit 2 clears flag
// - Bit 1 enables the interrupt request
// - Bit 0 selects edge or edge-and-level detection
// - Pin enable bit makes pin a source
// - Polarity bit: 0 falling/low, 1 rising/high
// - Falling edge: high then low sample
// - Rising edge: low then high sample
// - New edge only after all enabled inputs deasserted
// - Edge-only mode: valid edge sets flag
// - Request raised while flag and enable set
// - Level mode: edge or asserted level sets flag
// - Level mode: acknowledge fails while input asserted
// - Detection continues in wait and stop
`timescale 1ns/100ps
module pwi_unit
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic [pwi_pkg::ADDR_W-1:0] i_addr,
    input wire logic [pwi_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    input wire logic [PIN_COUNT-1:0] i_wake_pins,
    input wire logic i_wait_mode,
    input wire logic i_stop_mode,
    output logic [pwi_pkg::DATA_W-1:0] o_rdata,
    output logic o_irq_request,
    output logic o_wake,
    output logic o_event_irq
);
    import pwi_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (PIN_COUNT < 1 || PIN_COUNT > MAX_PINS)
    begin : g_bad_pins
        $error("PIN_COUNT must be 1 to 8");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Asserted sense per pin: polarity 1 means high is asserted
    function automatic logic [PIN_COUNT-1:0] asserted_of(
        input logic [PIN_COUNT-1:0] pins,
        input logic [PIN_COUNT-1:0] pol
    );
        asserted_of = ~(pins ^ pol);
    endfunction

    function automatic logic hit(
        input logic strobe,
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] target
    );
        hit = strobe && (addr == target);
    endfunction

    // ****************************************************************
    // Pin sampling
    // ****************************************************************
    logic [PIN_COUNT-1:0] pins_now;
    logic [PIN_COUNT-1:0] pins_prev_reg;
    logic [PIN_COUNT-1:0] pins_prev_next;

    pwi_pin_sync #(.WIDTH(PIN_COUNT)) u_sync
    (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_wake_pins),
        .o_sync(pins_now)
    );

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic mode_reg;
    logic mode_next;
    logic ie_reg;
    logic ie_next;
    logic flag_reg;
    logic flag_next;
    logic armed_reg;
    logic armed_next;
    logic [DATA_W-1:0] pe_reg;
    logic [DATA_W-1:0] pe_next;
    logic [DATA_W-1:0] pol_reg;
    logic [DATA_W-1:0] pol_next;
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_status_next;
    logic [EVT_W-1:0] evt_enable_reg;
    logic [EVT_W-1:0] evt_enable_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic irq_reg;
    logic irq_next;
    logic wake_reg;
    logic wake_next;
    logic event_irq_reg;
    logic event_irq_next;

    // ****************************************************************
    // Detection
    // ****************************************************************
    logic [PIN_COUNT-1:0] pin_en;
    logic [PIN_COUNT-1:0] pin_pol;
    logic [PIN_COUNT-1:0] asserted_now;
    logic [PIN_COUNT-1:0] asserted_prev;
    logic [PIN_COUNT-1:0] edge_vec;
    logic edge_any;
    logic level_any;
    logic all_deasserted;
    logic sc_write;
    logic ack_write;
    logic ack_refused;

    always_comb
    begin
        pin_en = pe_reg[PIN_COUNT-1:0];
        pin_pol = pol_reg[PIN_COUNT-1:0];
        asserted_now = asserted_of(pins_now, pin_pol) & pin_en;
        asserted_prev = asserted_of(pins_prev_reg, pin_pol) & pin_en;
        // Deasserted in one cycle, asserted in the next
        edge_vec = asserted_now & ~asserted_prev;
        // Disarmed after an edge until every enabled pin lets go
        edge_any = armed_reg && (|edge_vec);
        level_any = |asserted_now;
        all_deasserted = !level_any;
        pins_prev_next = pins_now;
        armed_next = armed_reg ? !edge_any : all_deasserted;
    end

    // ****************************************************************
    // Event flag and control
    // ****************************************************************
    always_comb
    begin
        sc_write = hit(i_write, i_addr, ADDR_STATUS_CONTROL);
        ack_write = sc_write && i_wdata[SC_ACK_BIT];
        // Level mode refuses the acknowledge while a pin is held
        ack_refused = ack_write && mode_reg && level_any;
        mode_next = sc_write ? i_wdata[SC_MODE_BIT] : mode_reg;
        ie_next = sc_write ? i_wdata[SC_IE_BIT] : ie_reg;
        flag_next = flag_reg;
        if (ack_write && !ack_refused)
        begin
            flag_next = 1'b0;
        end
        // Set wins over a same-cycle acknowledge
        if (edge_any)
        begin
            flag_next = 1'b1;
        end
        if (mode_reg && level_any)
        begin
            flag_next = 1'b1;
        end
        pe_next = hit(i_write, i_addr, ADDR_PIN_ENABLE) ? i_wdata : pe_reg;
        pol_next = hit(i_write, i_addr, ADDR_POLARITY) ? i_wdata : pol_reg;
    end

    // ****************************************************************
    // Event status block
    // ****************************************************************
    logic [EVT_W-1:0] evt_set;

    always_comb
    begin
        evt_set = '0;
        evt_set[EVT_FLAG_RISE] = flag_next && !flag_reg;
        evt_set[EVT_EDGE_SEEN] = edge_any;
        evt_set[EVT_ACK_REFUSED] = ack_refused;
        evt_status_next = evt_status_reg;
        if (hit(i_write, i_addr, ADDR_EVT_CLEAR))
        begin
            evt_status_next = evt_status_reg & ~i_wdata[EVT_W-1:0];
        end
        evt_status_next = evt_status_next | evt_set;
        evt_enable_next = evt_enable_reg;
        if (hit(i_write, i_addr, ADDR_EVT_ENABLE))
        begin
            evt_enable_next = i_wdata[EVT_W-1:0];
        end
    end

    // ****************************************************************
    // Outputs and read port
    // ****************************************************************
    always_comb
    begin
        irq_next = flag_next && ie_next;
        // Detection never stops, so a held request wakes the core
        wake_next = irq_next && (i_wait_mode || i_stop_mode);
        event_irq_next = |(evt_status_next & evt_enable_next);
        rdata_next = '0;
        if (i_read)
        begin
            unique case (i_addr)
                ADDR_STATUS_CONTROL:
                begin
                    // Acknowledge bit is write-only
                    rdata_next = {SC_RESERVED_VALUE, flag_reg, 1'b0, ie_reg, mode_reg};
                end
                ADDR_PIN_ENABLE:
                begin
                    rdata_next = pe_reg;
                end
                ADDR_POLARITY:
                begin
                    rdata_next = pol_reg;
                end
                ADDR_EVT_STATUS:
                begin
                    rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_status_reg};
                end
                ADDR_EVT_ENABLE:
                begin
                    rdata_next = {{(DATA_W-EVT_W){1'b0}}, evt_enable_reg};
                end
                default:
                begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge i_clock)
    begin
        if (!i_reset_n)
        begin
            mode_reg <= 1'b0;
            ie_reg <= 1'b0;
            flag_reg <= 1'b0;
            armed_reg <= 1'b0;
            pe_reg <= RESET_BYTE;
            pol_reg <= RESET_BYTE;
            pins_prev_reg <= '0;
            evt_status_reg <= RESET_EVT;
            evt_enable_reg <= RESET_EVT;
            rdata_reg <= RESET_BYTE;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            event_irq_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            ie_reg <= ie_next;
            flag_reg <= flag_next;
            armed_reg <= armed_next;
            pe_reg <= pe_next;
            pol_reg <= pol_next;
            pins_prev_reg <= pins_prev_next;
            evt_status_reg <= evt_status_next;
            evt_enable_reg <= evt_enable_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            event_irq_reg <= event_irq_next;
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq_request = irq_reg;
    assign o_wake = wake_reg;
    assign o_event_irq = event_irq_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);

    logic sc_read;
    assign sc_read = hit(i_read, i_addr, ADDR_STATUS_CONTROL);

    reserved_zero_a: assert property (sc_read |=> o_rdata[7:4] == 4'h0)
        else $error("reserved bits not zero");
    flag_read_a: assert property (sc_read |=> o_rdata[SC_FLAG_BIT] == $past(flag_reg))
        else $error("flag readback wrong");
    ack_clears_a: assert property (ack_write && !mode_reg && !edge_any |=> !flag_reg)
        else $error("acknowledge did not clear flag");
    ie_write_a: assert property (sc_write |=> ie_reg == $past(i_wdata[SC_IE_BIT]))
        else $error("irq enable not stored");
    mode_write_a: assert property (sc_write |=> mode_reg == $past(i_wdata[SC_MODE_BIT]))
        else $error("detect mode not stored");
    flag_hold_a: assert property (sc_write && !i_wdata[SC_ACK_BIT] && !edge_any && !(mode_reg && level_any)
        |=> flag_reg == $past(flag_reg))
        else $error("flag changed by write");
    irq_level_a: assert property (o_irq_request == (flag_reg && ie_reg))
        else $error("irq request not flag and enable");
    pin_excluded_a: assert property (pe_reg == 8'h00 |-> !edge_any && !level_any)
        else $error("disabled pin detected");
    // Pin 0 stands for all pins in the edge checks
    fall_detect_a: assert property (armed_reg && pe_reg[0] && !pol_reg[0] && pins_prev_reg[0] && !pins_now[0]
        |-> edge_any)
        else $error("falling edge missed");
    rise_detect_a: assert property (armed_reg && pe_reg[0] && pol_reg[0] && !pins_prev_reg[0] && pins_now[0]
        |-> edge_any)
        else $error("rising edge missed");
    // Disarmed until every enabled pin is released
    rearm_wait_a: assert property (edge_any |=> !armed_reg)
        else $error("edge seen before release");
    rearm_hold_a: assert property (!armed_reg && level_any |=> !armed_reg && !edge_any)
        else $error("rearmed while pin held");
    edge_sets_a: assert property (edge_any |=> flag_reg ##0 o_irq_request == ie_reg)
        else $error("edge did not set flag");
    level_sets_a: assert property (mode_reg && level_any |=> flag_reg)
        else $error("level did not set flag");
    ack_refused_a: assert property (ack_write && mode_reg && level_any |=> flag_reg ##0 evt_status_reg[2])
        else $error("acknowledge cleared held level");
    ack_readback_a: assert property (sc_read |=> !o_rdata[SC_ACK_BIT])
        else $error("acknowledge bit reads one");
    wake_out_a: assert property (flag_reg && ie_reg && i_stop_mode |=> o_wake || !flag_reg || !ie_reg)
        else $error("wake not raised");

    edge_irq_c: cover property (edge_any && ie_reg ##1 o_irq_request);
    level_refuse_c: cover property (ack_refused ##1 flag_reg);
    wake_c: cover property (o_wake);
    level_mode_c: cover property (mode_reg && level_any && !flag_reg ##1 flag_reg);
    ack_clear_c: cover property (ack_write && flag_reg ##1 !flag_reg);
endmodule

// ---- testbench/pwi_switch_model.sv ----
/*
 * Model of the external switches on the wake pins.
 * Assumes the bench commands presses; a released switch rests at the
 * deasserted level of its pin's polarity.
 */
`timescale 1ns/100ps
module pwi_switch_model
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic [PIN_COUNT-1:0] i_press,
    input wire logic [PIN_COUNT-1:0] i_pol,
    output logic [PIN_COUNT-1:0] o_pins
);
    // Pressed shows the asserted level, released the deasserted one
    assign o_pins = i_press ~^ i_pol;
endmodule

// ---- testbench/tb_pin_edge_level_wake_interrupt.sv ----
/*
 * Self-checking bench for the pin wake interrupt unit.
 * Assumes a 50 ns clock and a bus master that never waits.
 */
`timescale 1ns/100ps
module tb_pin_edge_level_wake_interrupt;
    import pwi_pkg::*;
    logic i_clock, i_reset_n, i_write, i_read, i_wait_mode, i_stop_mode;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, rv, pol, pe, pr;
    logic [7:0] i_press, pins;
    logic o_irq_request, o_wake, o_event_irq, ie;
    int fail_count = 0;
    int samples_checked = 0;

    pwi_unit #(.PIN_COUNT(8)) pwi_unit_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read), .i_wake_pins(pins), .i_wait_mode(i_wait_mode),
        .i_stop_mode(i_stop_mode), .o_rdata(o_rdata), .o_irq_request(o_irq_request), .o_wake(o_wake),
        .o_event_irq(o_event_irq));
    pwi_switch_model #(.PIN_COUNT(8)) pwi_switch_model_inst (.i_press(i_press), .i_pol(pol), .o_pins(pins));

    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // ****************************************************************
    // Bus tasks and checks
    // ****************************************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge i_clock);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_write <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_clock);
        i_read <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1 rv = o_rdata;
    endtask

    function automatic logic [7:0] sc(input logic f, input logic e, input logic m);
        return {4'h0, f, 1'b0, e, m};
    endfunction

    // Mask, set polarity, enable pins, acknowledge, then enable
    task automatic cfg(input logic m, input logic e, input logic [7:0] p, input logic [7:0] en);
        wr(ADDR_STATUS_CONTROL, sc(0, 0, m));
        wr(ADDR_POLARITY, p);
        // Switches rest at the level the unit now treats as released
        pol <= p;
        wr(ADDR_PIN_ENABLE, en);
        cyc(6);
        wr(ADDR_STATUS_CONTROL, sc(0, 0, m) | 8'h04);
        wr(ADDR_STATUS_CONTROL, sc(0, e, m));
    endtask

    task automatic summarize;
        $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clock);
        fail_count++;
        summarize();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        {i_reset_n, i_write, i_read, i_wait_mode, i_stop_mode} = 5'h0;
        i_addr = 16'h0000;
        i_wdata = 8'h00;
        i_press = 8'h00;
        pol = 8'h00;
        void'($urandom(32'he5dd));
        cyc(6);
        i_reset_n <= 1'b1;
        rd(ADDR_STATUS_CONTROL); chk(rv, RESET_BYTE);
        rd(ADDR_PIN_ENABLE); chk(rv, RESET_BYTE);
        rd(ADDR_POLARITY); chk(rv, RESET_BYTE);
        wr(16'h0040, 8'hff);
        rd(16'h0040); chk(rv, 8'h00);
        wr(ADDR_STATUS_CONTROL, 8'hff);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h03);
        $display("test registers done");
        for (int k = 0; k < 8; k++)
        begin
            ie = k[0];
            pe = 8'h01 << k;
            pr = 8'($urandom);
            // Pins 0,1,4,5 falling, pins 2,3,6,7 rising
            cfg(0, ie, k[1] ? (pr | pe) : (pr & ~pe), pe);
            i_wait_mode <= k[1];
            i_stop_mode <= k[2];
            i_press <= ~pe;
            cyc(6);
            rd(ADDR_STATUS_CONTROL); chk(rv, sc(0, ie, 0));
            i_press <= pe;
            cyc(6);
            rd(ADDR_STATUS_CONTROL); chk(rv, sc(1, ie, 0));
            chk(o_irq_request, ie);
            chk(o_wake, ie & (k[1] | k[2]));
            wr(ADDR_STATUS_CONTROL, sc(0, ie, 0));
            rd(ADDR_STATUS_CONTROL); chk(rv, sc(1, ie, 0));
            wr(ADDR_STATUS_CONTROL, sc(0, ie, 0) | 8'h04);
            rd(ADDR_STATUS_CONTROL); chk(rv, sc(0, ie, 0));
            i_press <= 8'h00;
            cyc(6);
            rd(ADDR_STATUS_CONTROL); chk(rv, sc(0, ie, 0));
        end
        $display("test edge pins done");
        cfg(0, 1, 8'($urandom) | 8'h01, 8'h03);
        i_press <= 8'h01;
        cyc(6);
        wr(ADDR_STATUS_CONTROL, 8'h06);
        i_press <= 8'h03;
        cyc(6);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h02);
        i_press <= 8'h00;
        cyc(6);
        i_press <= 8'h02;
        cyc(6);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h0a);
        i_press <= 8'h00;
        $display("test rearm done");
        cfg(1, 1, 8'($urandom), 8'h10);
        wr(ADDR_EVT_CLEAR, 8'h07);
        i_press <= 8'h10;
        cyc(6);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h0b);
        wr(ADDR_STATUS_CONTROL, 8'h07);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h0b);
        rd(ADDR_EVT_STATUS); chk(rv, 8'h07);
        chk(o_event_irq, 0);
        wr(ADDR_EVT_ENABLE, 8'h04);
        cyc(3);
        chk(o_event_irq, 1);
        rd(ADDR_EVT_ENABLE); chk(rv, 8'h04);
        wr(ADDR_EVT_CLEAR, 8'h07);
        cyc(3);
        chk(o_event_irq, 0);
        i_press <= 8'h00;
        cyc(6);
        wr(ADDR_STATUS_CONTROL, 8'h07);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h03);
        // Level alone, pin already held when enabled
        wr(ADDR_PIN_ENABLE, 8'h00);
        i_press <= 8'h20;
        cyc(6);
        wr(ADDR_PIN_ENABLE, 8'h20);
        cyc(6);
        rd(ADDR_STATUS_CONTROL); chk(rv, 8'h0b);
        $display("test level mode done");
        summarize();
    end
endmodule
